// ==== core/bus_port_map.vh ====
// Purpose: constants for the host-side controller of the peripheral bus port
// Assumes: mclk at 100 MHz; software reaches the controller over Avalon-MM
// Notes: register offsets 0, 4, 8 and c are byte addresses of 32-bit words; status sits at offset 1
//
// Contract
// - 8-bit bus: program reads use program_fetch_n; hosts without it hold high.
// - top address pin may be chip select; host drives it inactive when idle.
// - standard variant reset polarity selectable; host holds it at least 100 ns.
// - low-voltage variant reset active low, 500 ns held, then 500 ns quiet.
// - non-multiplexed host connects low data lines to the first general port.
`ifndef BUS_PORT_MAP_VH
`define BUS_PORT_MAP_VH

`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_WDATA 4'h8
`define REG_RDATA 4'hc
`define REG_STATUS 4'h1

`define CTRL_GO 0
`define CTRL_WRITE 1
`define CTRL_FETCH 2
`define CTRL_MUXED 3
`define CTRL_WIDE 4
`define CTRL_RWDIR 5
`define CTRL_ALEHI 6
`define CTRL_RSTHI 7
`define CTRL_LOWV 8
`define CTRL_CSUSE 9
`define CTRL_RESET 10
`define CTRL_TOPADDR 11
`define CTRL_STROBE 12
`define CTRL_RESET_VAL 16'h0000

`define ST_BUSY 0
`define ST_RSTBUSY 1

`define T_CLK_NS 10
`define T_RST_STD_NS 100
`define T_RST_LV_NS 500
`define T_QUIET_LV_NS 500
// counts are the ns figures above over the clock period, rounded up;
// plain numbers so they can follow a sized prefix
`define N_RST_STD 10
`define N_RST_LV 50
`define N_QUIET_LV 50
`define N_SETUP 2
`define N_STROBE 4

`endif

// ==== core/pulse_timer.v ====
// Purpose: one-shot down counter for phase timing
// Assumes: load takes priority over counting
// Notes: done is high while the count is zero
`timescale 1ns/1ps
module pulse_timer (
    input wire mclk,
    input wire rst,
    input wire load,
    input wire [7:0] count,
    output wire done
);
    reg [7:0] cnt_q;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    assign done = (cnt_q == 8'h00);
endmodule

// ==== core/sync2.v ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input is asynchronous to mclk
// Notes: first stage is read by the second only
`timescale 1ns/1ps
module sync2 #(
    parameter W = 16
) (
    input wire mclk,
    input wire rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta_q;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// ==== core/bus_port_host.v ====
// Purpose: host controller driving the peripheral's bus pins from Avalon-MM orders
// Assumes: device is clockless; all timing comes from this controller
// Notes: one bus cycle per order, none when the reset bit is set in the same order; reset sequence runs on the reset control bit
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "bus_port_map.vh"
module bus_port_host (
    input wire mclk,
    input wire rst,
    input wire [3:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    output reg [31:0] avsReadData,
    output wire avsWaitRequest,
    output reg [15:0] busAddrOut,
    output reg [15:0] busDataOut,
    output reg busDataLowOe,
    output reg busDataHighOe,
    input wire [15:0] busDataIn,
    output reg portDataOut,
    output reg address_latch_pulse,
    output reg readPin,
    output reg writePin,
    output reg program_fetch_n,
    output reg upper_byte_enable_n,
    output reg top_address_input,
    output reg resetPin
);
    localparam S_IDLE = 3'd0;
    localparam S_ALE = 3'd1;
    localparam S_SETUP = 3'd2;
    localparam S_STROBE = 3'd3;
    localparam S_HOLD = 3'd4;
    localparam S_RST = 3'd5;
    localparam S_QUIET = 3'd6;

    reg [15:0] ctrl_q;
    reg [15:0] addr_q;
    reg [15:0] wdata_q;
    reg [15:0] rdata_q;
    reg [2:0] state_q;
    // high in the cycle where read data already stands in avsReadData
    reg readDone_q;
    reg loadTimer;
    reg [7:0] loadCount;
    wire timerDone;
    wire [15:0] dataSync;

    wire muxed = ctrl_q[`CTRL_MUXED];
    wire wide = ctrl_q[`CTRL_WIDE];
    wire isWrite = ctrl_q[`CTRL_WRITE];
    wire lowV = ctrl_q[`CTRL_LOWV];
    wire aleIdle = ~ctrl_q[`CTRL_ALEHI];
    wire rstActive = lowV ? 1'b0 : ctrl_q[`CTRL_RSTHI];
    wire busy = (state_q != S_IDLE);

    pulse_timer timer (
        .mclk(mclk),
        .rst(rst),
        .load(loadTimer),
        .count(loadCount),
        .done(timerDone)
    );

    sync2 #(.W(16)) dataSyncer (
        .mclk(mclk),
        .rst(rst),
        .din(busDataIn),
        .dout(dataSync)
    );

    // bus writes only accepted while idle; avoids changing pins mid-cycle
    // reads wait one cycle so the data stand at the edge that ends the wait
    assign avsWaitRequest = (avsWrite & busy) | (avsRead & ~readDone_q);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET_VAL;
            addr_q <= 16'h0000;
            wdata_q <= 16'h0000;
        end else if (avsWrite && !busy) begin
            case (avsAddress)
                `REG_CTRL: ctrl_q <= avsWriteData[15:0];
                `REG_ADDR: addr_q <= avsWriteData[15:0];
                `REG_WDATA: wdata_q <= avsWriteData[15:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end else if (state_q == S_IDLE) begin
            ctrl_q <= ctrl_q;
        end else begin
            ctrl_q[`CTRL_GO] <= 1'b0;
            ctrl_q[`CTRL_RESET] <= 1'b0;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            avsReadData <= 32'h00000000;
            readDone_q <= 1'b0;
        end else begin
            readDone_q <= avsRead & ~readDone_q;
            if (avsRead && !readDone_q) begin
                case (avsAddress)
                    `REG_CTRL: avsReadData <= {16'h0000, ctrl_q};
                    `REG_ADDR: avsReadData <= {16'h0000, addr_q};
                    `REG_WDATA: avsReadData <= {16'h0000, wdata_q};
                    `REG_RDATA: avsReadData <= {16'h0000, rdata_q};
                    default: avsReadData <= 32'h00000000;
                endcase
                if (avsAddress == `REG_STATUS) begin
                    avsReadData <= {30'h00000000, state_q == S_RST || state_q == S_QUIET, busy};
                end
            end
        end
    end

    always @* begin
        loadTimer = 1'b0;
        loadCount = 8'h00;
        case (state_q)
            S_IDLE: begin
                loadTimer = 1'b1;
                loadCount = ctrl_q[`CTRL_RESET] ?
                    (lowV ? 8'd`N_RST_LV : 8'd`N_RST_STD) : 8'd`N_SETUP;
            end
            S_ALE: begin
                loadTimer = timerDone;
                loadCount = 8'd`N_SETUP;
            end
            S_SETUP: begin
                loadTimer = timerDone;
                loadCount = 8'd`N_STROBE;
            end
            S_STROBE: begin
                loadTimer = timerDone;
                loadCount = 8'd`N_SETUP;
            end
            S_RST: begin
                loadTimer = timerDone;
                loadCount = 8'd`N_QUIET_LV;
            end
            default: begin
                loadTimer = 1'b0;
                loadCount = 8'h00;
            end
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            rdata_q <= 16'h0000;
            busAddrOut <= 16'h0000;
            busDataOut <= 16'h0000;
            busDataLowOe <= 1'b0;
            busDataHighOe <= 1'b0;
            portDataOut <= 1'b0;
            address_latch_pulse <= 1'b0;
            readPin <= 1'b1;
            writePin <= 1'b1;
            program_fetch_n <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            top_address_input <= 1'b1;
            resetPin <= 1'b1;
        end else begin
            case (state_q)
                S_IDLE: begin
                    resetPin <= ~rstActive;
                    address_latch_pulse <= aleIdle;
                    // every strobe form idles high, so the device sees no access
                    readPin <= 1'b1;
                    writePin <= 1'b1;
                    program_fetch_n <= 1'b1;
                    upper_byte_enable_n <= 1'b1;
                    busDataLowOe <= 1'b0;
                    busDataHighOe <= 1'b0;
                    portDataOut <= 1'b0;
                    // chip select parked inactive to keep device in standby
                    // otherwise the pin is a plain logic level
                    top_address_input <= ctrl_q[`CTRL_CSUSE] ? 1'b1 : ctrl_q[`CTRL_TOPADDR];
                    if (ctrl_q[`CTRL_RESET]) begin
                        resetPin <= rstActive;
                        state_q <= S_RST;
                    end else if (ctrl_q[`CTRL_GO]) begin
                        busAddrOut <= addr_q;
                        if (ctrl_q[`CTRL_CSUSE]) begin
                            top_address_input <= 1'b0;
                        end
                        upper_byte_enable_n <= ~wide;
                        if (muxed) begin
                            address_latch_pulse <= ~aleIdle;
                            busDataLowOe <= 1'b1;
                            busDataHighOe <= wide;
                            busDataOut <= addr_q;
                            state_q <= S_ALE;
                        end else begin
                            // latch pin left idle as plain logic input
                            state_q <= S_SETUP;
                        end
                    end
                end
                S_ALE: begin
                    if (timerDone) begin
                        // trailing edge captures address and byte enable
                        address_latch_pulse <= aleIdle;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (timerDone) begin
                        busDataOut <= wdata_q;
                        busDataLowOe <= isWrite;
                        busDataHighOe <= isWrite & wide;
                        portDataOut <= isWrite & ~muxed;
                        if (ctrl_q[`CTRL_RWDIR]) begin
                            // direction level, read pin then acts as the strobe
                            writePin <= ~isWrite;
                            readPin <= 1'b0;
                        end else if (isWrite) begin
                            writePin <= 1'b0;
                        end else if (ctrl_q[`CTRL_FETCH] && !wide) begin
                            program_fetch_n <= 1'b0;
                        end else begin
                            // read and data strobe forms share one low pulse
                            readPin <= 1'b0;
                        end
                        state_q <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    if (timerDone) begin
                        if (!isWrite) begin
                            rdata_q <= wide ? dataSync : {8'h00, dataSync[7:0]};
                        end
                        readPin <= 1'b1;
                        writePin <= 1'b1;
                        program_fetch_n <= 1'b1;
                        state_q <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    // inputs held steady so the device can idle on latched outputs
                    if (timerDone) begin
                        busDataLowOe <= 1'b0;
                        busDataHighOe <= 1'b0;
                        portDataOut <= 1'b0;
                        upper_byte_enable_n <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                S_RST: begin
                    if (timerDone) begin
                        resetPin <= ~rstActive;
                        state_q <= lowV ? S_QUIET : S_IDLE;
                    end
                end
                S_QUIET: begin
                    if (timerDone) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// ==== bench/bus_port_host_chk.sv ====
// Purpose: pin-level checks on the bus port host controller
// Assumes: mode bits are shadowed from accepted control writes
// Notes: control shadow follows accepted writes only
`timescale 1ns/1ps
`include "bus_port_map.vh"
module bus_port_host_chk (
    input wire mclk,
    input wire rst,
    input wire [3:0] avsAddress,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire avsWaitRequest,
    input wire [15:0] busDataOut,
    input wire busDataLowOe,
    input wire busDataHighOe,
    input wire address_latch_pulse,
    input wire readPin,
    input wire writePin,
    input wire program_fetch_n,
    input wire upper_byte_enable_n,
    input wire top_address_input
);
    reg [15:0] ctrlQ;
    wire ctrlWr = avsWrite && !avsWaitRequest && avsAddress == `REG_CTRL;
    always @(posedge mclk or posedge rst) begin
        if (rst)
            ctrlQ <= 16'h0000;
        else if (ctrlWr)
            ctrlQ <= avsWriteData[15:0];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_fetch_narrow: assert property (!program_fetch_n |-> !ctrlQ[`CTRL_WIDE])
        else $error("fetch strobe in wide mode");
    a_upper_wide: assert property (!upper_byte_enable_n |-> ctrlQ[`CTRL_WIDE])
        else $error("upper enable in narrow mode");
    a_upper_drive: assert property (busDataHighOe && !writePin |-> !upper_byte_enable_n)
        else $error("upper byte written without enable");
    a_no_overlap: assert property (!ctrlQ[`CTRL_RWDIR] |-> readPin || writePin)
        else $error("read and write strobes together");
    a_write_hold: assert property (!writePin && !$past(writePin) && !ctrlQ[`CTRL_RWDIR]
        |-> $stable(busDataOut)) else $error("write data moved in pulse");
    a_strobe_len: assert property ($fell(readPin) |-> !readPin [*4])
        else $error("read strobe too short");
    a_drive_read: assert property (busDataLowOe && !ctrlQ[`CTRL_RWDIR]
        |-> readPin && program_fetch_n) else $error("bus driven during read");
    a_ale_done: assert property ($fell(readPin) && ctrlQ[`CTRL_MUXED]
        |-> address_latch_pulse != ctrlQ[`CTRL_ALEHI]) else $error("latch open");
    a_cs_select: assert property (ctrlQ[`CTRL_CSUSE] && (!readPin || !writePin)
        |-> !top_address_input) else $error("strobe while deselected");
    a_top_level: assert property ($past(ctrlWr) && !ctrlQ[`CTRL_CSUSE]
        |-> ##[0:3] top_address_input == ctrlQ[`CTRL_TOPADDR]) else $error("top level");
endmodule

// ==== bench/device_model.sv ====
// Purpose: behavioural peripheral answering the controller's pins
// Assumes: memory word is the address xor a fixed pattern
// Notes: released data lines show the inverse of the last word read out
`timescale 1ns/1ps
`include "bus_port_map.vh"
module device_model (
    input wire [15:0] cfg,
    input wire [15:0] addrPins,
    input wire [15:0] dataPins,
    input wire ale,
    input wire rdPin,
    input wire wrPin,
    input wire fetchN,
    input wire upperN,
    input wire topAddr,
    input wire resetPin,
    output logic [15:0] dataOut,
    output logic [15:0] wrAddr,
    output logic [15:0] wrData,
    output logic quietBad
);
    logic [15:0] latchQ;
    logic [15:0] last = 16'h0000;
    logic awake = 1'b0;
    realtime relT = -1.0e6;
    wire muxed = cfg[`CTRL_MUXED];
    wire wide = cfg[`CTRL_WIDE];
    wire rwd = cfg[`CTRL_RWDIR];
    wire [15:0] addr = muxed ? (wide ? latchQ : {addrPins[15:8], latchQ[7:0]}) : addrPins;
    wire [15:0] word = addr ^ 16'ha5c3;
    wire sel = !cfg[`CTRL_CSUSE] || !topAddr;
    wire inRst = cfg[`CTRL_LOWV] ? !resetPin : resetPin == cfg[`CTRL_RSTHI];
    wire rdStb = rwd ? !rdPin && wrPin : !rdPin || (!wide && !fetchN);
    wire wrStb = rwd ? !rdPin && !wrPin : !wrPin;
    wire rdAct = sel && !inRst && rdStb;
    wire wrAct = sel && !inRst && wrStb;
    initial quietBad = 1'b0;
    always @* if (ale == cfg[`CTRL_ALEHI]) latchQ = dataPins;
    always @* begin
        dataOut = ~last;
        if (rdAct) begin
            dataOut[7:0] = word[7:0];
            if (wide && !upperN)
                dataOut[15:8] = word[15:8];
        end
    end
    always @(negedge rdAct) last = word;
    always @(negedge wrAct) begin
        wrAddr = addr;
        wrData = {(wide && !upperN) ? dataPins[15:8] : 8'h00, dataPins[7:0]};
    end
    always @(negedge inRst) relT = $realtime;
    always @(posedge rdAct or posedge wrAct)
        if (cfg[`CTRL_LOWV] && $realtime - relT < 500.0) quietBad = 1'b1;
    // power only while inputs settle; deselect forces standby
    always @(addrPins or ale or rdPin or wrPin or fetchN or topAddr) begin
        awake = sel;
        #5 awake = 1'b0;
    end
endmodule

// ==== bench/bus_port_host_tb.sv ====
// Purpose: self-checking bench for the bus port host controller
// Assumes: device side is the behavioural model
// Notes: read table walks every bus form, write table all but the narrow non-multiplexed one; reset tests count pin cycles
`timescale 1ns/1ps
`include "bus_port_map.vh"
`define CHK(nm, e, a) begin checksDone++; if ((a) !== (e)) begin nErrors++; \
    $display("Error %s expected %h seen %h", nm, e, a); end end
module bus_port_host_tb;
    localparam logic [15:0] MUX = 16'h0001 << `CTRL_MUXED;
    localparam logic [15:0] WIDE = 16'h0001 << `CTRL_WIDE;
    localparam logic [15:0] WR = 16'h0001 << `CTRL_WRITE;
    localparam logic [15:0] RWD = 16'h0001 << `CTRL_RWDIR;
    localparam logic [15:0] ALEH = 16'h0001 << `CTRL_ALEHI;
    localparam logic [15:0] RSTH = 16'h0001 << `CTRL_RSTHI;
    localparam logic [15:0] LOWV = 16'h0001 << `CTRL_LOWV;
    localparam logic [15:0] CSU = 16'h0001 << `CTRL_CSUSE;
    localparam logic [15:0] TOP = 16'h0001 << `CTRL_TOPADDR;
    localparam logic [15:0] FET = 16'h0001 << `CTRL_FETCH;
    localparam logic [15:0] STB = 16'h0001 << `CTRL_STROBE;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [15:0] cfg = 16'h0000;
    logic [31:0] rd;
    logic rstLvl = 1'b0;
    logic rstClr = 1'b0;
    logic portSeen;
    integer rstCnt = 0;
    integer nErrors = 0;
    integer checksDone = 0;
    wire [31:0] avsReadData;
    wire avsWaitRequest, loOe, hiOe, portOut, aleP, rdP, wrP, fetN, upN, topA, rstP, quietBad;
    wire [15:0] busAddrOut, busDataOut, devOut, wrAddr, wrData;
    wire [15:0] busWire = {hiOe ? busDataOut[15:8] : devOut[15:8],
                           loOe ? busDataOut[7:0] : devOut[7:0]};
    always #5 mclk = ~mclk;
    always @(posedge mclk) rstCnt <= rstClr ? 0 : rstCnt + (rstP === rstLvl);
    bus_port_host uut (.mclk(mclk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .busAddrOut(busAddrOut), .busDataOut(busDataOut),
        .busDataLowOe(loOe), .busDataHighOe(hiOe), .busDataIn(busWire), .portDataOut(portOut),
        .address_latch_pulse(aleP), .readPin(rdP), .writePin(wrP), .program_fetch_n(fetN),
        .upper_byte_enable_n(upN), .top_address_input(topA), .resetPin(rstP));
    device_model dev (.cfg(cfg), .addrPins(busAddrOut), .dataPins(busWire), .ale(aleP),
        .rdPin(rdP), .wrPin(wrP), .fetchN(fetN), .upperN(upN), .topAddr(topA),
        .resetPin(rstP), .dataOut(devOut), .wrAddr(wrAddr), .wrData(wrData), .quietBad(quietBad));
    task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= 1'b1;
        @(posedge mclk);
        while (avsWaitRequest) @(posedge mclk);
        avsWrite <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdReg(input logic [3:0] a, output logic [31:0] d);
        avsAddress <= a;
        avsRead <= 1'b1;
        @(posedge mclk);
        while (avsWaitRequest) @(posedge mclk);
        d = avsReadData;
        avsRead <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic waitIdle(input integer bitNo);
        integer n;
        n = 0;
        rd = 32'h1 << bitNo;
        while (rd[bitNo] && n < 300) begin
            rdReg(`REG_STATUS, rd);
            portSeen = portSeen | portOut;
            n++;
        end
        `CHK("status idle", 1'b0, rd[bitNo])
    endtask
    task automatic busCycle(input logic [15:0] m, input logic [15:0] a, input logic [15:0] d);
        cfg = m;
        portSeen = 1'b0;
        wrReg(`REG_ADDR, {16'h0, a});
        wrReg(`REG_WDATA, {16'h0, d});
        wrReg(`REG_CTRL, {16'h0, m | (16'h0001 << `CTRL_GO)});
        waitIdle(`ST_BUSY);
    endtask
    task automatic resetSeq(input logic [15:0] m, input logic lvl, input integer expN);
        cfg = m;
        rstLvl = lvl;
        // settle the polarity first so the idle level is never counted
        wrReg(`REG_CTRL, {16'h0, m});
        rstClr <= 1'b1;
        @(posedge mclk);
        rstClr <= 1'b0;
        wrReg(`REG_CTRL, {16'h0, m | (16'h0001 << `CTRL_RESET)});
        busCycle(m | MUX, 16'h0042, 16'h0000);
        `CHK("quiet time", 1'b0, quietBad)
        // pin asserts on the load edge and drops one edge after the count ends
        `CHK("reset width", expN + 1, rstCnt)
    endtask
    task automatic readModes();
        logic [15:0] t [9] = '{MUX, MUX | WIDE | ALEH, 16'h0, WIDE, FET, STB, RWD, CSU | MUX, TOP};
        logic [15:0] a;
        for (int i = 0; i < 9; i++) begin
            a = 16'h1230 + 16'h0111 * i;
            busCycle(t[i], a, 16'h0000);
            rdReg(`REG_RDATA, rd);
            `CHK("read data", {16'h0, (a ^ 16'ha5c3) & (t[i][`CTRL_WIDE] ? 16'hffff : 16'h00ff)}, rd)
            `CHK("top pin", t[i][`CTRL_CSUSE] | t[i][`CTRL_TOPADDR], topA)
        end
    endtask
    task automatic writeModes();
        logic [15:0] t [4] = '{WR | WIDE, WR | MUX, WR | RWD | WIDE, WR | MUX | WIDE | CSU};
        for (int i = 0; i < 4; i++) begin
            busCycle(t[i], 16'h0a50 + 16'h0203 * i, 16'hbe0f + 16'h1111 * i);
            `CHK("write addr", 16'h0a50 + 16'h0203 * i, wrAddr)
            `CHK("write data", (16'hbe0f + 16'h1111 * i) & (t[i][`CTRL_WIDE] ? 16'hffff : 16'h00ff), wrData)
            `CHK("port drive", !t[i][`CTRL_MUXED], portSeen)
        end
    endtask
    task automatic conclude();
        $display("Checks %0d errors %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        resetSeq(RSTH, 1'b1, `N_RST_STD);
        resetSeq(16'h0, 1'b0, `N_RST_STD);
        resetSeq(LOWV | RSTH, 1'b0, `N_RST_LV);
        readModes();
        writeModes();
        conclude();
    end
    initial begin
        #400us;
        nErrors++;
        $display("Error watchdog expected finish seen hang");
        conclude();
    end
endmodule
bind bus_port_host bus_port_host_chk chk (.mclk(mclk), .rst(rst), .avsAddress(avsAddress),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsWaitRequest(avsWaitRequest),
    .busDataOut(busDataOut), .busDataLowOe(busDataLowOe), .busDataHighOe(busDataHighOe),
    .address_latch_pulse(address_latch_pulse), .readPin(readPin), .writePin(writePin),
    .program_fetch_n(program_fetch_n), .upper_byte_enable_n(upper_byte_enable_n),
    .top_address_input(top_address_input));
